/* File: mac_ctrl_low.sv */
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mac_ctrl_defines.svh"
module mac_ctrl_low #(
  parameter int DEFER_CYC = `DEFER_BITS * `BIT_NS / `CLK_NS
) (
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // mii pins
  input  wire logic        mii_crs,
  input  wire logic        mii_col,
  // transmit engine
  input  wire logic        tx_pending,
  input  wire logic        tx_done,
  output logic             tx_start,
  output logic             tx_abort,
  // receive path into fifo
  input  wire logic        rx_in_valid,
  input  wire logic [31:0] rx_in_data,
  output logic             rx_in_ready,
  output logic             frame_intake_on,
  // receive system bus writes
  output logic             rx_wr_valid,
  output logic [31:0]      rx_wr_data,
  output logic             rx_wr_burst,
  output logic             rx_wr_last,
  input  wire logic        rx_wr_ready,
  // pause frame address
  output logic [47:0]      pause_addr
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q;
  logic [3:0]  flags_q;
  logic [4:0]  retry_q;
  logic [1:0]  crs_s_q, col_s_q;
  logic        crs, col;
  logic        aw_q, w_q;
  logic [3:0]  awa_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        wr_go;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [3:0]  set_flags;
  logic [31:0] bmask;

  // only the second stage is ever read
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      crs_s_q <= 2'h0;
      col_s_q <= 2'h0;
    end else if (ce) begin
      crs_s_q <= {crs_s_q[0], mii_crs};
      col_s_q <= {col_s_q[0], mii_col};
    end
  end
  assign crs = crs_s_q[1];
  assign col = col_s_q[1];

  ////////////////////////////////////////////////////////////////////////
  // address and data latched apart, response once both are held
  assign wr_go = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awa_q         <= 4'h0;
      wd_q          <= 32'h0;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OK;
    end else if (ce) begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr[5:2] == 4'h0 && s_axi_awaddr[31:6] == 26'h0 ? `ADDR_CTRL :
                 s_axi_awaddr[31:2] == 30'h1 ? `ADDR_STAT : 4'hf;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awa_q == `ADDR_CTRL || awa_q == `ADDR_STAT) ? `RESP_OK : `RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{ws_q[i]}};
    end
  end

  // reserved bit never stored
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RST;
    end else if (ce && wr_go && awa_q == `ADDR_CTRL) begin
      ctrl_q <= (ctrl_q & ~bmask) | (wd_q & bmask & `CTRL_WMASK);
    end
  end

  // write one to clear, a new event wins over the clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= 4'h0;
    end else if (ce) begin
      if (wr_go && awa_q == `ADDR_STAT && ws_q[0]) begin
        flags_q <= (flags_q & ~wd_q[3:0]) | set_flags;
      end else begin
        flags_q <= flags_q | set_flags;
      end
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    if (s_axi_araddr[31:2] == 30'h0) begin
      rd_val = ctrl_q;
    end else if (s_axi_araddr[31:2] == 30'h1) begin
      rd_val = {23'h0, retry_q, flags_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OK;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? `RESP_OK : `RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pause_addr      <= `PAUSE_ADDR0;
      frame_intake_on <= 1'b0;
    end else if (ce) begin
      pause_addr      <= ctrl_q[`B_ORDER] ? `PAUSE_ADDR1 : `PAUSE_ADDR0;
      frame_intake_on <= ctrl_q[`B_INTAKE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit deferral and collision back-off
  mac_ctrl_pkg::tx_state_t st_q;
  logic [23:0] lfsr_q;
  logic [14:0] defer_q;
  logic [9:0]  slots_q;
  logic [9:0]  cyc_q;
  logic [3:0]  nbits;
  logic [3:0]  cap;
  logic [9:0]  rmask;
  logic [4:0]  n_next;

  // free running, never gated by frame activity
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_q <= `LFSR_SEED;
    end else if (ce) begin
      lfsr_q <= {lfsr_q[22:0], lfsr_q[23] ^ lfsr_q[22] ^ lfsr_q[21] ^ lfsr_q[16]};
    end
  end

  assign n_next = retry_q + 5'h1;

  always_comb begin
    case (ctrl_q[`B_BL_LO +: 2])
      2'h0:    cap = 4'ha;
      2'h1:    cap = 4'h8;
      2'h2:    cap = 4'h6;
      default: cap = 4'h3;
    endcase
    nbits = (n_next > {1'b0, `K_MAX}) ? `K_MAX : n_next[3:0];
    if (nbits > cap) begin
      nbits = cap;
    end
    rmask = 10'((11'h1 << nbits) - 11'h1);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q      <= mac_ctrl_pkg::TX_IDLE;
      defer_q   <= 15'h0;
      slots_q   <= 10'h0;
      cyc_q     <= 10'h0;
      retry_q   <= 5'h0;
      tx_start  <= 1'b0;
      tx_abort  <= 1'b0;
      set_flags <= 4'h0;
    end else if (ce) begin
      tx_start  <= 1'b0;
      tx_abort  <= 1'b0;
      set_flags <= 4'h0;
      case (st_q)
        mac_ctrl_pkg::TX_IDLE: begin
          retry_q <= 5'h0;
          defer_q <= 15'h0;
          if (tx_pending && !tx_abort && ctrl_q[`B_SEND]) begin
            st_q <= mac_ctrl_pkg::TX_DEFER;
          end
        end
        mac_ctrl_pkg::TX_DEFER: begin
          if (!ctrl_q[`B_SEND]) begin
            st_q <= mac_ctrl_pkg::TX_IDLE;
          end else if (!crs) begin
            tx_start <= 1'b1;
            defer_q  <= 15'h0;
            st_q     <= mac_ctrl_pkg::TX_SEND;
          end else if (ctrl_q[`B_DCHK]) begin
            if (32'(defer_q) >= DEFER_CYC) begin
              tx_abort             <= 1'b1;
              set_flags[`S_EXDEF] <= 1'b1;
              st_q                 <= mac_ctrl_pkg::TX_IDLE;
            end else begin
              defer_q <= defer_q + 15'h1;
            end
          end
        end
        mac_ctrl_pkg::TX_SEND: begin
          if (col) begin
            if (ctrl_q[`B_RETRY_OFF] || retry_q == `MAX_RETRY) begin
              tx_abort             <= 1'b1;
              set_flags[`S_EXCOL] <= 1'b1;
              set_flags[`S_ABORT] <= 1'b1;
              st_q                 <= mac_ctrl_pkg::TX_IDLE;
            end else begin
              retry_q              <= n_next;
              set_flags[`S_RETRY] <= 1'b1;
              slots_q              <= lfsr_q[9:0] & rmask;
              cyc_q                <= 10'h0;
              st_q                 <= mac_ctrl_pkg::TX_BACKOFF;
            end
          end else if (tx_done) begin
            st_q <= mac_ctrl_pkg::TX_IDLE;
          end
        end
        mac_ctrl_pkg::TX_BACKOFF: begin
          // retry re-enters the carrier wait before starting
          if (slots_q == 10'h0) begin
            st_q <= mac_ctrl_pkg::TX_DEFER;
          end else if (cyc_q == 10'(`SLOT_CYC - 1)) begin
            cyc_q   <= 10'h0;
            slots_q <= slots_q - 10'h1;
          end else begin
            cyc_q <= cyc_q + 10'h1;
          end
        end
        default: st_q <= mac_ctrl_pkg::TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive fifo and system bus write master
  logic [31:0] mem_q [4];
  logic [1:0]  wp_q, rp_q;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  logic [1:0]  beats_q;
  logic        push, pop;

  assign push  = rx_in_valid && rx_in_ready && ctrl_q[`B_INTAKE];
  assign pop   = rx_wr_valid && rx_wr_ready;
  assign cnt_d = cnt_q + {2'h0, push} - {2'h0, pop};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q        <= 2'h0;
      cnt_q       <= 3'h0;
      rx_in_ready <= 1'b0;
    end else if (ce) begin
      cnt_q       <= cnt_d;
      rx_in_ready <= cnt_d != `FIFO_DEPTH;
      if (push) begin
        wp_q <= wp_q + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem_q[wp_q] <= rx_in_data;
    end
  end

  // data is preloaded so later beats go out with no wait
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rp_q        <= 2'h0;
      beats_q     <= 2'h0;
      rx_wr_valid <= 1'b0;
      rx_wr_burst <= 1'b0;
      rx_wr_last  <= 1'b0;
      rx_wr_data  <= 32'h0;
    end else if (ce) begin
      if (pop) begin
        rp_q <= rp_q + 2'h1;
      end
      if (!rx_wr_valid) begin
        // with bursts on, a single waits while words stream in so a burst can form
        if (cnt_q != 3'h0 && (!ctrl_q[`B_BURST] || cnt_q == `BURST_LEN || !push)) begin
          rx_wr_valid <= 1'b1;
          rx_wr_data  <= mem_q[rp_q];
          rx_wr_burst <= ctrl_q[`B_BURST] && cnt_q == `BURST_LEN;
          rx_wr_last  <= !(ctrl_q[`B_BURST] && cnt_q == `BURST_LEN);
          beats_q     <= 2'(`BURST_LEN - 3'h1);
        end
      end else if (pop) begin
        // one wait state on the first beat is the slave's to insert
        if (rx_wr_burst && beats_q != 2'h0) begin
          beats_q    <= beats_q - 2'h1;
          rx_wr_data <= mem_q[rp_q + 2'h1];
          rx_wr_last <= beats_q == 2'h1;
        end else begin
          rx_wr_valid <= 1'b0;
          rx_wr_burst <= 1'b0;
          rx_wr_last  <= 1'b0;
        end
      end
    end
  end

endmodule : mac_ctrl_low
`default_nettype wire

/* File: mac_ctrl_defines.svh */
// Behaviour
// - back-off slot count comes from a free-running 24-bit LFSR
// - retry count N picks LFSR bits, exponent K is min(N, 10)
// - limit field caps loaded bits: 00=10, 01=8, 10=6, 11=3
// - after collision wait R slot times, R below two to the K
// - abort after 16 retransmissions, set excess-collision and frame-abort flags
// - deferral check on: defer counter runs while pending under carrier, clears on start
// - deferral check on: beyond 24288 bit times abort and set excessive-defer flag
// - deferral check off: defer without limit while carrier stays active
// - burst off gives single writes only; burst on allows single or burst
// - receive bursts are exactly 4 words
// - burst starts only when receive FIFO holds 4 entries, else single writes
// - first burst beat takes one wait state, later beats none
// - frames go to the MII only while the send enable is 1
// - frames from the MII are taken only while the intake enable is 1
// - control bit 1 is reserved, reads zero, ignores writes
// - order bit 0 selects pause address 0x010000C28001
// - order bit 1 selects pause address 0x0180C2000001
`ifndef MAC_CTRL_DEFINES_SVH
`define MAC_CTRL_DEFINES_SVH
`define ADDR_CTRL      4'h0
`define ADDR_STAT      4'h4
`define CTRL_RST       32'h0000_0000
`define CTRL_WMASK     32'h0000_04fd
`define B_ORDER        0
`define B_INTAKE       2
`define B_SEND         3
`define B_BURST        4
`define B_DCHK         5
`define B_BL_LO        6
`define B_RETRY_OFF    10
`define S_RETRY        0
`define S_EXCOL        1
`define S_ABORT        2
`define S_EXDEF        3
`define PAUSE_ADDR0    48'h0100_00c2_8001
`define PAUSE_ADDR1    48'h0180_c200_0001
`define LFSR_SEED      24'h00_0001
`define MAX_RETRY      5'h10
`define K_MAX          4'ha
`define CLK_NS         10
`define BIT_NS         10
`define SLOT_BITS      512
`define SLOT_CYC       (`SLOT_BITS * `BIT_NS / `CLK_NS)
`define DEFER_BITS     24288
`define BURST_LEN      3'h4
`define FIFO_DEPTH     3'h4
`define RESP_OK        2'h0
`define RESP_ERR       2'h2
`endif

/* File: mac_ctrl_pkg.sv */
package mac_ctrl_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_DEFER, TX_SEND, TX_BACKOFF} tx_state_t;
endpackage : mac_ctrl_pkg

/* File: mac_ctrl_low_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_ctrl_defines.svh"
module mac_ctrl_low_monitor #(
  parameter int DEFER_CYC = 20
) (
  // clock, reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // transmit side
  input wire logic        mii_crs,
  input wire logic        tx_pending,
  input wire logic        tx_start,
  input wire logic        tx_abort,
  // receive bus side, pause address
  input wire logic        rx_wr_valid,
  input wire logic [31:0] rx_wr_data,
  input wire logic        rx_wr_burst,
  input wire logic        rx_wr_last,
  input wire logic        rx_wr_ready,
  input wire logic [47:0] pause_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [1:0] beat_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      beat_q <= 2'h0;
    else if (rx_wr_valid && rx_wr_ready && rx_wr_burst)
      beat_q <= rx_wr_last ? 2'h0 : beat_q + 2'h1;
  end
  // four edges cover the two sync flops plus the state register
  sequence carrier_s;
    mii_crs [*4];
  endsequence
  sequence beat_s;
    rx_wr_valid && rx_wr_ready && rx_wr_burst && !rx_wr_last;
  endsequence
  start_pend_a: assert property (tx_start |-> $past(tx_pending))
    else $error("start without pending frame");
  start_crs_a: assert property (carrier_s |=> !tx_start)
    else $error("start under carrier");
  abort_pulse_a: assert property (tx_abort |=> !tx_abort && !tx_start)
    else $error("abort not a single pulse");
  pause_sel_a: assert property (pause_addr == `PAUSE_ADDR0 || pause_addr == `PAUSE_ADDR1)
    else $error("pause address invalid");
  single_last_a: assert property (rx_wr_valid && !rx_wr_burst |-> rx_wr_last)
    else $error("single write without last");
  burst_len_a: assert property (rx_wr_valid && rx_wr_burst && rx_wr_last |-> beat_q == 2'h3)
    else $error("burst not four beats");
  burst_next_a: assert property (beat_s |=> rx_wr_valid && rx_wr_burst)
    else $error("gap inside burst");
  wr_hold_a: assert property (rx_wr_valid && !rx_wr_ready |=> rx_wr_valid && $stable(rx_wr_data))
    else $error("write beat not held");
endmodule : mac_ctrl_low_monitor
bind mac_ctrl_low mac_ctrl_low_monitor #(.DEFER_CYC(DEFER_CYC)) mon (.mclk, .sys_rst, .mii_crs,
  .tx_pending, .tx_start, .tx_abort, .rx_wr_valid, .rx_wr_data, .rx_wr_burst, .rx_wr_last,
  .rx_wr_ready, .pause_addr);
`default_nettype wire

/* File: rx_bus_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_bus_slave (
  // clock, reset, single-write stall
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  stall,
  // receive system bus
  input  wire logic        rx_wr_valid,
  input  wire logic [31:0] rx_wr_data,
  input  wire logic        rx_wr_burst,
  input  wire logic        rx_wr_last,
  output logic             rx_wr_ready
);
  logic [31:0] got[$];
  int          nb;
  logic [3:0]  w_q;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wr_ready <= 1'b0;
      w_q <= 4'h0;
      nb = 0;
    end else begin
      if (rx_wr_valid && rx_wr_ready) begin
        got.push_back(rx_wr_data);
        if (rx_wr_burst) nb++;
      end
      // ready stays up through a burst: zero waits after the first beat
      if (!rx_wr_valid || (rx_wr_ready && (rx_wr_last || !rx_wr_burst))) begin
        rx_wr_ready <= 1'b0;
        w_q <= 4'h0;
      end else if (!rx_wr_ready) begin
        if (rx_wr_burst || w_q >= stall) rx_wr_ready <= 1'b1;
        else w_q <= w_q + 4'h1;
      end
    end
  end
endmodule : rx_bus_slave
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_ctrl_defines.svh"
module tb_top;
  logic        mclk, sys_rst, awv, wv, brdy, arv, rrdy, crs, col, pend, done, iv;
  logic [31:0] awa, wd, ara, ind, rd;
  logic [3:0]  stall;
  logic [1:0]  resp;
  int          num_errors, samples_checked, cyc, n, b0, s0;
  wire logic   awr, wr, bv, arr, rv, st, ab, ir, ion, ov, ob, ol, ordy;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdat, od;
  wire logic [47:0] pa;
  mac_ctrl_low #(.DEFER_CYC(20)) dut (.mclk, .sys_rst, .ce(1'b1), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .mii_crs(crs), .mii_col(col), .tx_pending(pend), .tx_done(done), .tx_start(st),
    .tx_abort(ab), .rx_in_valid(iv), .rx_in_data(ind), .rx_in_ready(ir),
    .frame_intake_on(ion), .rx_wr_valid(ov), .rx_wr_data(od), .rx_wr_burst(ob),
    .rx_wr_last(ol), .rx_wr_ready(ordy), .pause_addr(pa));
  rx_bus_slave slv (.mclk, .sys_rst, .stall, .rx_wr_valid(ov), .rx_wr_data(od),
    .rx_wr_burst(ob), .rx_wr_last(ol), .rx_wr_ready(ordy));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wrr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    awa  <= a;
    wd   <= d;
    awv  <= 1'b1;
    wv   <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge mclk);
      if (awr && awv) awv <= 1'b0;
      if (wr && wv) wv <= 1'b0;
    end while (!bv);
    resp = br;
    brdy <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [31:0] a);
    @(posedge mclk);
    ara  <= a;
    arv  <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge mclk);
      if (arr && arv) arv <= 1'b0;
    end while (!rv);
    rd = rdat;
    resp = rr;
    rrdy <= 1'b0;
  endtask : rdr
  // sel 0 start, 1 abort, 2 either; n is lim when nothing came
  task automatic wt(input int sel, input int lim);
    n = 0;
    do begin
      @(posedge mclk);
      if ((sel != 1 && st) || (sel != 0 && ab)) return;
      n++;
    end while (n < lim);
  endtask : wt
  task automatic fin(input string s);
    @(posedge mclk);
    pend <= 1'b0;
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    $display("test %s done", s);
  endtask : fin
  task automatic push(input logic [31:0] d);
    @(posedge mclk);
    ind <= d;
    iv  <= 1'b1;
    do @(posedge mclk); while (!ir);
    iv <= 1'b0;
  endtask : push
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {awv, wv, brdy, arv, rrdy, crs, col, pend, done, iv} = '0;
    awa = '0;
    wd = '0;
    ara = '0;
    ind = '0;
    stall = 4'h0;
    sys_rst = 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rdr(`ADDR_CTRL);
    chk(rd, `CTRL_RST);
    wrr(`ADDR_CTRL, 32'hffff_ffff);
    chk(resp, `RESP_OK);
    rdr(`ADDR_CTRL);
    chk(rd, `CTRL_WMASK);
    chk(pa, `PAUSE_ADDR1);
    wrr(`ADDR_CTRL, 32'h0);
    rdr(`ADDR_CTRL);
    chk(pa, `PAUSE_ADDR0);
    rdr(32'h8);
    chk(resp, `RESP_ERR);
    wrr(32'h8, 32'h0);
    chk(resp, `RESP_ERR);
    $display("test registers done");
    pend <= 1'b1;
    wt(0, 30);
    chk(n, 30);
    wrr(`ADDR_CTRL, 32'h8);
    wt(0, 10);
    chk(n < 10, 1);
    fin("enable");
    crs <= 1'b1;
    repeat (4) @(posedge mclk);
    pend <= 1'b1;
    wt(2, 60);
    chk(n, 60);
    crs <= 1'b0;
    wt(0, 10);
    chk(n < 10, 1);
    fin("defer_off");
    wrr(`ADDR_CTRL, 32'h28);
    crs <= 1'b1;
    repeat (4) @(posedge mclk);
    pend <= 1'b1;
    wt(1, 40);
    chk(n >= 20 && n < 40, 1);
    pend <= 1'b0;
    crs <= 1'b0;
    rdr(`ADDR_STAT);
    chk(rd[3], 1);
    wrr(`ADDR_STAT, 32'h8);
    rdr(`ADDR_STAT);
    chk(rd[3], 0);
    $display("test defer_on done");
    wrr(`ADDR_CTRL, 32'h408);
    pend <= 1'b1;
    wt(0, 10);
    col <= 1'b1;
    wt(1, 10);
    chk(n < 10, 1);
    col <= 1'b0;
    pend <= 1'b0;
    rdr(`ADDR_STAT);
    chk(rd[2:1], 2'h3);
    wrr(`ADDR_STAT, 32'hf);
    $display("test retry_off done");
    wrr(`ADDR_CTRL, 32'hc8);
    pend <= 1'b1;
    wt(0, 10);
    col <= 1'b1;
    repeat (3) @(posedge mclk);
    col <= 1'b0;
    // first retry: K is 1, so zero or one slot of 512 cycles
    wt(0, 1100);
    chk(n < 40 || (n >= 500 && n < 560), 1);
    rdr(`ADDR_STAT);
    chk(rd[0], 1);
    chk(rd[8:4], 5'h1);
    fin("backoff");
    wrr(`ADDR_CTRL, 32'h0);
    push(32'h11);
    repeat (20) @(posedge mclk);
    chk(slv.got.size(), 0);
    chk(ion, 0);
    wrr(`ADDR_CTRL, 32'h4);
    for (int i = 0; i < 4; i++) push(32'ha0 + i);
    repeat (30) @(posedge mclk);
    chk(slv.got.size(), 4);
    chk(slv.nb, 0);
    chk(ion, 1);
    for (int i = 0; i < 4; i++) chk(slv.got[i], 32'ha0 + i);
    $display("test rx_single done");
    s0 = slv.got.size();
    b0 = slv.nb;
    stall <= 4'h8;
    wrr(`ADDR_CTRL, 32'h14);
    // valid held across words so the fifo fills before the first write
    @(posedge mclk);
    ind <= 32'hb0;
    iv  <= 1'b1;
    for (int i = 1; i <= 5; i++) begin
      do @(posedge mclk); while (!ir);
      ind <= 32'hb0 + i;
    end
    iv <= 1'b0;
    repeat (60) @(posedge mclk);
    chk(slv.got.size() - s0, 5);
    chk(slv.nb - b0, 4);
    for (int i = 0; i < 5; i++) chk(slv.got[s0 + i], 32'hb0 + i);
    $display("test rx_burst done");
    results();
  end
endmodule : tb_top
`default_nettype wire
